// >>> rtl/partrc_top.sv
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module partrc_top #(
  parameter int HOLD_CYC = partrc_pkg::RESET_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic datapath_reset,
  output logic timing_reset,
  output logic [15:0] clock_output_config,
  output logic [15:0] timing_clock_source,
  output logic [15:0] timing_rate
);
  logic [2:0] page_reg;
  logic [15:0] pctl2_reg;
  logic soft_rst_reg;
  logic tim_rst_reg;
  logic [15:0] coc_reg;
  logic [15:0] clksrc_reg;
  logic [15:0] rate_reg;
  logic [31:0] rdata_next;
  logic hit;
  logic wr;
  logic [4:0] idx;
  partrc_if dp_if ();
  partrc_if tm_if ();

  function automatic logic sel(input logic [4:0] i, input logic [2:0] pg,
                               input logic [4:0] ri, input logic [2:0] rp);
    sel = (i == ri) && (pg == rp);
  endfunction : sel

  // ---------------------------------------------------------------------
  // apb decode, zero wait states, always served
  // ---------------------------------------------------------------------
  assign idx = paddr[6:2];
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    hit = 1'b1;
    rdata_next = 32'h0000_0000;
    if (paddr[31:7] != 25'h0 || paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (idx == partrc_pkg::IDX_PAGE_SEL) begin
      rdata_next = {29'h0, page_reg};
    end else if (sel(idx, page_reg, partrc_pkg::IDX_PHY_CONTROL_TWO,
                     partrc_pkg::PAGE_EXT)) begin
      rdata_next = {16'h0, pctl2_reg};
      rdata_next[partrc_pkg::SOFT_RESET_BIT] = soft_rst_reg;
    end else if (sel(idx, page_reg, partrc_pkg::IDX_TIMING_CONTROL,
                     partrc_pkg::PAGE_TIMING)) begin
      rdata_next[partrc_pkg::TIMING_RESET_BIT] = tim_rst_reg;
    end else if (sel(idx, page_reg, partrc_pkg::IDX_CLOCK_OUTPUT_CONFIG,
                     partrc_pkg::PAGE_TIMING)) begin
      rdata_next = {16'h0, coc_reg};
    end else if (sel(idx, page_reg, partrc_pkg::IDX_TIMING_CLOCK_SOURCE,
                     partrc_pkg::PAGE_TIMING)) begin
      rdata_next = {16'h0, clksrc_reg};
    end else if (sel(idx, page_reg, partrc_pkg::IDX_TIMING_RATE,
                     partrc_pkg::PAGE_TIMING)) begin
      rdata_next = {16'h0, rate_reg};
    end else if (sel(idx, page_reg, partrc_pkg::IDX_STATUS,
                     partrc_pkg::PAGE_OWN)) begin
      rdata_next = {30'h0, tm_if.busy, dp_if.busy};
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_next;
    end
  end

  // ---------------------------------------------------------------------
  // page select and configuration registers
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      page_reg <= partrc_pkg::PAGE_EXT;
    end else if (wr && hit && idx == partrc_pkg::IDX_PAGE_SEL) begin
      page_reg <= pwdata[2:0];
    end
  end

  // soft reset never touches this register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pctl2_reg <= partrc_pkg::PCTL2_RST;
    end else if (wr && sel(idx, page_reg, partrc_pkg::IDX_PHY_CONTROL_TWO,
                           partrc_pkg::PAGE_EXT)) begin
      pctl2_reg <= pwdata[15:0];
    end
  end

  // spared by the timing reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      coc_reg <= partrc_pkg::COC_RST;
      clksrc_reg <= partrc_pkg::CLKSRC_RST;
    end else begin
      if (wr && sel(idx, page_reg, partrc_pkg::IDX_CLOCK_OUTPUT_CONFIG,
                    partrc_pkg::PAGE_TIMING)) begin
        coc_reg <= pwdata[15:0];
      end
      if (wr && sel(idx, page_reg, partrc_pkg::IDX_TIMING_CLOCK_SOURCE,
                    partrc_pkg::PAGE_TIMING)) begin
        clksrc_reg <= pwdata[15:0];
      end
    end
  end

  // timing rate register cleared by the timing reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rate_reg <= partrc_pkg::RATE_RST;
    end else if (tm_if.busy) begin
      rate_reg <= partrc_pkg::RATE_RST;
    end else if (wr && sel(idx, page_reg, partrc_pkg::IDX_TIMING_RATE,
                           partrc_pkg::PAGE_TIMING)) begin
      rate_reg <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------------
  // self-clearing reset bits
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      soft_rst_reg <= 1'b0;
    end else if (!soft_rst_reg && wr && pwdata[partrc_pkg::SOFT_RESET_BIT]
                 && sel(idx, page_reg, partrc_pkg::IDX_PHY_CONTROL_TWO,
                        partrc_pkg::PAGE_EXT)) begin
      soft_rst_reg <= 1'b1;
    end else if (dp_if.done) begin
      soft_rst_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tim_rst_reg <= 1'b0;
    end else if (!tim_rst_reg && wr && pwdata[partrc_pkg::TIMING_RESET_BIT]
                 && sel(idx, page_reg, partrc_pkg::IDX_TIMING_CONTROL,
                        partrc_pkg::PAGE_TIMING)) begin
      tim_rst_reg <= 1'b1;
    end else if (tm_if.done) begin
      tim_rst_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // sequencers and reset outputs
  // ---------------------------------------------------------------------
  assign dp_if.start = soft_rst_reg && !dp_if.busy && !dp_if.done;
  assign tm_if.start = tim_rst_reg && !tm_if.busy && !tm_if.done;

  partrc_seq #(.HOLD_CYC(HOLD_CYC)) u_dp_seq (
    .mclk(mclk),
    .reset_n(reset_n),
    .sq(dp_if.seq)
  );

  partrc_seq #(.HOLD_CYC(HOLD_CYC)) u_tm_seq (
    .mclk(mclk),
    .reset_n(reset_n),
    .sq(tm_if.seq)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      datapath_reset <= 1'b0;
      timing_reset <= 1'b0;
    end else begin
      datapath_reset <= dp_if.busy;
      timing_reset <= tm_if.busy;
    end
  end

  assign clock_output_config = coc_reg;
  assign timing_clock_source = clksrc_reg;
  assign timing_rate = rate_reg;
endmodule : partrc_top

// >>> rtl/partrc_pkg.sv
// Function
// - data-path soft reset bit 9 resets all transmit and receive work
// - data-path soft reset leaves every register value untouched
// - register access keeps working during and after soft reset
// - timing reset bit clears timing clock, its logic and its registers
// - timing reset spares clock-output config and clock-source registers
// - phy_control_two sits at offset 1Ch in extended page 0
// - timing_control_reg sits at offset 14h in page 4
package partrc_pkg;
  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [4:0] IDX_PAGE_SEL = 5'h13;
  localparam logic [4:0] IDX_PHY_CONTROL_TWO = 5'h1C;
  localparam logic [4:0] IDX_TIMING_CONTROL = 5'h14;
  localparam logic [4:0] IDX_CLOCK_OUTPUT_CONFIG = 5'h1A;
  localparam logic [4:0] IDX_TIMING_CLOCK_SOURCE = 5'h1B;
  localparam logic [4:0] IDX_TIMING_RATE = 5'h18;
  localparam logic [4:0] IDX_STATUS = 5'h1E;
  localparam logic [2:0] PAGE_EXT = 3'h0;
  localparam logic [2:0] PAGE_TIMING = 3'h4;
  localparam logic [2:0] PAGE_OWN = 3'h7;
  // ---------------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------------
  localparam int SOFT_RESET_BIT = 9;
  localparam int TIMING_RESET_BIT = 0;
  localparam logic [15:0] PCTL2_RST = 16'h0000;
  localparam logic [15:0] COC_RST = 16'h0000;
  localparam logic [15:0] CLKSRC_RST = 16'h0000;
  localparam logic [15:0] RATE_RST = 16'h0000;
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int RESET_HOLD_NS = 1000;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {partrc_idle_e, partrc_hold_e, partrc_done_e}
    partrc_state_e;
endpackage : partrc_pkg

// >>> rtl/partrc_if.sv
`timescale 1ns/1ps
interface partrc_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport seq (input start, output busy, output done);
endinterface : partrc_if

// >>> rtl/partrc_seq.sv
`timescale 1ns/1ps
module partrc_seq #(
  parameter int HOLD_CYC = partrc_pkg::RESET_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  partrc_if.seq sq
);
  partrc_pkg::partrc_state_e state_reg;
  logic [15:0] cnt_reg;
  // ---------------------------------------------------------------------
  // hold a reset for a fixed time, then report completion
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= partrc_pkg::partrc_idle_e;
      cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        partrc_pkg::partrc_idle_e: begin
          if (sq.start) begin
            state_reg <= partrc_pkg::partrc_hold_e;
            cnt_reg <= 16'(HOLD_CYC - 1);
          end
        end
        partrc_pkg::partrc_hold_e: begin
          if (cnt_reg == 16'h0000) begin
            state_reg <= partrc_pkg::partrc_done_e;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        default: begin
          state_reg <= partrc_pkg::partrc_idle_e;
        end
      endcase
    end
  end
  assign sq.busy = (state_reg == partrc_pkg::partrc_hold_e);
  assign sq.done = (state_reg == partrc_pkg::partrc_done_e);
endmodule : partrc_seq

// >>> sim/partrc_chk.sv
`timescale 1ns/1ps
module partrc_chk #(
  parameter int HOLD_CYC = 4
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic datapath_reset,
  input wire logic timing_reset,
  input wire logic [15:0] clock_output_config,
  input wire logic [15:0] timing_clock_source,
  input wire logic [15:0] timing_rate
);
  // ------------------------------------------------------------
  // page tracking and checks
  // ------------------------------------------------------------
  logic [2:0] pg;
  wire wr = psel && penable && pwrite;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pg <= 3'h0;
    end else if (wr && paddr == 32'h0000_004C) begin
      pg <= pwdata[2:0];
    end
  end
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_dp; wr && paddr == 32'h0000_0070 && pg == 3'h0 && pwdata[9]
    && !datapath_reset |-> ##[1:3] datapath_reset; endproperty
  a_dp: assert property (p_dp) else $error("no soft reset");
  property p_dpl; $rose(datapath_reset) |-> ##HOLD_CYC $fell(datapath_reset);
  endproperty
  a_dpl: assert property (p_dpl) else $error("soft reset length");
  property p_tm; wr && paddr == 32'h0000_0050 && pg == 3'h4 && pwdata[0]
    && !timing_reset |-> ##[1:3] timing_reset; endproperty
  a_tm: assert property (p_tm) else $error("no timing reset");
  property p_tml; $rose(timing_reset) |-> ##HOLD_CYC $fell(timing_reset);
  endproperty
  a_tml: assert property (p_tml) else $error("timing reset length");
  property p_rate; $fell(timing_reset) |-> timing_rate == 16'h0000; endproperty
  a_rate: assert property (p_rate) else $error("rate kept");
  property p_keep; timing_reset && !wr |=> $stable(clock_output_config)
    && $stable(timing_clock_source); endproperty
  a_keep: assert property (p_keep) else $error("clock cfg lost");
  property p_soft; datapath_reset && !wr |=> $stable(timing_rate)
    && $stable(clock_output_config); endproperty
  a_soft: assert property (p_soft) else $error("reg changed");
  property p_map; psel && penable && paddr == 32'h0000_0070 && pg == 3'h0
    |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("map error");
  c_dp: cover property ($rose(datapath_reset));
  c_tm: cover property ($rose(timing_reset));
  c_err: cover property (pslverr);
endmodule : partrc_chk

bind partrc_top partrc_chk #(.HOLD_CYC(HOLD_CYC)) i_partrc_chk (.mclk,
  .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .datapath_reset, .timing_reset, .clock_output_config,
  .timing_clock_source, .timing_rate);

// >>> sim/partrc_bench.sv
`timescale 1ns/1ps
module partrc_bench;
  // ------------------------------------------------------------
  // signals and tasks
  // ------------------------------------------------------------
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd_data;
  logic pready, pslverr, datapath_reset, timing_reset, rd_err;
  logic [15:0] clock_output_config, timing_clock_source, timing_rate;
  int fail_count = 0;
  int n_checks = 0;
  always #2.5 mclk = ~mclk;
  partrc_top #(.HOLD_CYC(10)) i_partrc_top (.mclk, .reset_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .datapath_reset, .timing_reset, .clock_output_config,
    .timing_clock_source, .timing_rate);
  task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 32'(a);
    pwdata <= 32'(d);
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a);
    apb(1'b0, a, 16'h0000);
  endtask : rd
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task poll(input logic [7:0] a, input int b);
    for (int i = 0; i < 20; i++) begin
      rd(a);
      if (rd_data[b] === 1'b0) break;
    end
    chk("self clear", 1'h0, rd_data[b]);
  endtask : poll
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  task t_map;
    chk("coc", 16'h0000, clock_output_config);
    rd(8'h00);
    chk("err", 1'h1, rd_err);
    chk("rdata", 16'h0000, rd_data);
    wr(8'h4C, 16'h0004);
    rd(8'h70);
    chk("err", 1'h1, rd_err);
    $display("t_map done");
  endtask : t_map
  task t_timing;
    wr(8'h68, 16'h1234);
    wr(8'h6C, 16'hBEEF);
    wr(8'h60, 16'h5A5A);
    wr(8'h50, 16'h0001);
    rd(8'h50);
    chk("tbit", 1'h1, rd_data[0]);
    chk("tmr", 1'h1, timing_reset);
    poll(8'h50, 0);
    chk("tmr", 1'h0, timing_reset);
    rd(8'h60);
    chk("rate", 16'h0000, rd_data);
    rd(8'h68);
    chk("coc", 16'h1234, rd_data);
    chk("src", 16'hBEEF, timing_clock_source);
    wr(8'h60, 16'h00C3);
    $display("t_timing done");
  endtask : t_timing
  task t_soft;
    wr(8'h4C, 16'h0000);
    wr(8'h70, 16'h0255);
    rd(8'h70);
    chk("sbit", 16'h0255, rd_data);
    chk("dpr", 1'h1, datapath_reset);
    wr(8'h4C, 16'h0007);
    rd(8'h78);
    chk("stat", 32'h0000_0001, rd_data);
    chk("err", 1'h0, rd_err);
    wr(8'h4C, 16'h0004);
    rd(8'h60);
    chk("rate", 16'h00C3, rd_data);
    chk("err", 1'h0, rd_err);
    wr(8'h4C, 16'h0000);
    poll(8'h70, 9);
    chk("pc2", 16'h0055, rd_data);
    chk("dpr", 1'h0, datapath_reset);
    chk("coc", 16'h1234, clock_output_config);
    $display("t_soft done");
  endtask : t_soft
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_map();
    t_timing();
    t_soft();
    give_verdict();
  end
  initial begin
    #20000;
    fail_count++;
    give_verdict();
  end
endmodule : partrc_bench
